// ===== logic/afe_consts.svh
// Constants for the front-end mode control block
`ifndef AFE_CONSTS_SVH
`define AFE_CONSTS_SVH
`define TARGET_ADDR 7'h48
`define OFS_STATUS 8'h00
`define OFS_LOCK 8'h01
`define OFS_GAIN 8'h10
`define OFS_REF 8'h11
`define OFS_MODE 8'h12
`define GAIN_RST 8'h1c
`define REF_RST 8'h00
`define MODE_RST 8'h00
`define LOCK_RST 1'b1
`define MODE_MASK 8'h87
`define GAIN_MASK 8'h1f
`define LOCK_MASK 8'h01
`define SHORT_BIT 7
`define OPM_LSB 0
`define OPM_MSB 2
`define GAIN_LSB 2
`define GAIN_MSB 4
`define GAIN_EXT 3'h0
`define POR_NS 1000
`define CLK_NS 25
`define POR_CYC ((`POR_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== logic/afe_pkg.sv
// Types for the front-end mode control block
package afe_pkg;
  typedef enum logic [2:0] {
    OPM_DEEP_SLEEP = 3'h0,
    OPM_GALVANIC = 3'h1,
    OPM_STANDBY = 3'h2,
    OPM_AMPEROMETRIC = 3'h3,
    OPM_TEMP_AMP_OFF = 3'h6,
    OPM_TEMP_AMP_ON = 3'h7
  } opm_t;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WDATA = 7'h08,
    ST_WACK = 7'h10,
    ST_RDATA = 7'h20,
    ST_RACK = 7'h40
  } ser_state_t;
endpackage : afe_pkg

// ===== logic/afe_reg_if.sv
// Register access carrier between serial engine and register bank
`timescale 1ns/100ps
interface afe_reg_if;
  logic wr_stb;
  logic [7:0] ptr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport engine (output wr_stb, output ptr, output wdata, input rdata);
  modport bank (input wr_stb, input ptr, input wdata, output rdata);
endinterface : afe_reg_if

// ===== logic/afe_reg_bank.sv
// Register bank with lock protection and ready status
`timescale 1ns/100ps
`include "afe_consts.svh"
module afe_reg_bank (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register access
  afe_reg_if.bank rif,
  // Register contents
  output logic ready,
  output logic [7:0] gain_reg,
  output logic [7:0] ref_reg,
  output logic [7:0] mode_reg
);
  logic [7:0] gain_ff, nxt_gain;
  logic [7:0] ref_ff, nxt_ref;
  logic [7:0] mode_ff, nxt_mode;
  logic lock_ff, nxt_lock;
  logic [7:0] rd_ff, nxt_rd;
  logic [15:0] por_ff, nxt_por;
  logic rdy_ff, nxt_rdy;

  // Next values: writes, protection, power-on count
  always_comb
  begin
    nxt_gain = gain_ff;
    nxt_ref = ref_ff;
    nxt_mode = mode_ff;
    nxt_lock = lock_ff;
    nxt_por = por_ff;
    nxt_rdy = rdy_ff;
    if (!rdy_ff)
    begin
      nxt_por = por_ff + 16'h0001;
      nxt_rdy = (por_ff == 16'(`POR_CYC - 1)); // R15
    end
    if (rif.wr_stb)
    begin
      unique case (rif.ptr)
        `OFS_LOCK: nxt_lock = rif.wdata[0];
        `OFS_GAIN: if (!lock_ff) nxt_gain = rif.wdata & `GAIN_MASK; // R14
        `OFS_REF: if (!lock_ff) nxt_ref = rif.wdata; // R14
        `OFS_MODE: nxt_mode = rif.wdata & `MODE_MASK; // R2
        default: ;
      endcase
    end
    unique case (rif.ptr)
      `OFS_STATUS: nxt_rd = {7'h00, rdy_ff}; // R15
      `OFS_LOCK: nxt_rd = {7'h00, lock_ff};
      `OFS_GAIN: nxt_rd = gain_ff;
      `OFS_REF: nxt_rd = ref_ff;
      `OFS_MODE: nxt_rd = mode_ff;
      default: nxt_rd = 8'h00;
    endcase
  end

  // State registers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      gain_ff <= `GAIN_RST;
      ref_ff <= `REF_RST;
      mode_ff <= `MODE_RST; // R1
      lock_ff <= `LOCK_RST;
      rd_ff <= 8'h00;
      por_ff <= 16'h0000;
      rdy_ff <= 1'b0;
    end
    else
    begin
      gain_ff <= nxt_gain;
      ref_ff <= nxt_ref;
      mode_ff <= nxt_mode;
      lock_ff <= nxt_lock;
      rd_ff <= nxt_rd;
      por_ff <= nxt_por;
      rdy_ff <= nxt_rdy;
    end
  end

  assign rif.rdata = rd_ff;
  assign ready = rdy_ff;
  assign gain_reg = gain_ff;
  assign ref_reg = ref_ff;
  assign mode_reg = mode_ff;
endmodule : afe_reg_bank

// ===== logic/afe_mode_control_and_select.sv
// Serial target, module select gating and mode decode for the sensor front end
// Function
// R1: Decode 3-bit mode field: sleep, galvanic, standby, amperometric, two temperature modes.
// R2: Bit 7 enables electrode short switch, reset clear; bits 6:3 reserved.
// R3: Temperature with amplifier on routes sensor to main pin, potentiostat to second pin.
// R4: Amperometric mode powers control and current-to-voltage amplifiers.
// R5: Galvanic mode powers off control amplifier, keeps amplifier non-inverting.
// R6: Host enables reference bypass when using galvanic mode.
// R7: Host selects external gain setting when external feedback resistor fitted.
// R8: Device answers only at one fixed target address.
// R9: Bus communication only while module select is low.
// R10: Unselected devices never acknowledge.
// R11: Host selects exactly one device at a time.
// R12: Host restores gain, reference and mode registers from memory at startup.
// R13: Host addresses companion memory with low address bit zero.
// R14: Gain and reference writes only while lock clear; mode never locked.
// R15: Ready bit reads zero until power-on completes.
// R16: Host writes zero to reserved bits, ignores readback.
// R17: Deselected device releases data line; deselect mid-transfer returns interface to idle.
`timescale 1ns/100ps
`include "afe_consts.svh"
module afe_mode_control_and_select (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Serial bus, sampled
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Module select
  input wire logic module_select_n,
  // Analog controls
  output logic control_amp_on,
  output logic current_to_voltage_amp_on,
  output logic current_to_voltage_non_inverting,
  output logic temp_sensor_on,
  output logic temp_to_main_output,
  output logic pstat_to_second_feedback,
  output logic electrode_short_switch_enable,
  output logic device_ready,
  output logic gain_external
);
  afe_reg_if rif ();
  logic [7:0] gain_reg, ref_reg, mode_reg;
  afe_pkg::ser_state_t st_ff, nxt_st;
  logic scl_ff, sda_ff, nxt_scl, nxt_sda;
  logic [7:0] sh_ff, nxt_sh;
  logic [3:0] cnt_ff, nxt_cnt;
  logic rw_ff, nxt_rw;
  logic first_ff, nxt_first;
  logic [7:0] ptr_ff, nxt_ptr;
  logic drv_ff, nxt_drv;
  logic wr_ff, nxt_wr;
  logic [7:0] wd_ff, nxt_wd;
  logic [3:0] ctl_ff, nxt_ctl;
  logic [2:0] rt_ff, nxt_rt;
  logic rise, fall, start, stop, sel;

  afe_reg_bank bank (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .rif(rif),
    .ready(device_ready),
    .gain_reg(gain_reg),
    .ref_reg(ref_reg),
    .mode_reg(mode_reg)
  );

  // Bus edge and condition detection
  assign sel = !module_select_n; // R9
  assign rise = scl_in && !scl_ff;
  assign fall = !scl_in && scl_ff;
  assign start = scl_in && scl_ff && sda_ff && !sda_in;
  assign stop = scl_in && scl_ff && !sda_ff && sda_in;
  assign rif.wr_stb = wr_ff;
  assign rif.ptr = ptr_ff;
  assign rif.wdata = wd_ff;

  // Serial engine next state
  always_comb
  begin
    nxt_scl = scl_in;
    nxt_sda = sda_in;
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_rw = rw_ff;
    nxt_first = first_ff;
    nxt_ptr = ptr_ff;
    nxt_drv = drv_ff;
    nxt_wr = 1'b0;
    nxt_wd = wd_ff;
    if (!sel)
    begin
      nxt_st = afe_pkg::ST_IDLE; // R17
      nxt_drv = 1'b0; // R17
    end
    else if (start)
    begin
      nxt_st = afe_pkg::ST_ADDR;
      nxt_cnt = 4'h0;
      nxt_drv = 1'b0;
    end
    else if (stop)
    begin
      nxt_st = afe_pkg::ST_IDLE;
      nxt_drv = 1'b0;
    end
    else
    begin
      unique case (st_ff)
        afe_pkg::ST_IDLE: nxt_drv = 1'b0;
        afe_pkg::ST_ADDR, afe_pkg::ST_WDATA:
          if (rise)
          begin
            nxt_sh = {sh_ff[6:0], sda_in};
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (fall && cnt_ff == 4'h8)
          begin
            nxt_cnt = 4'h0;
            if (st_ff == afe_pkg::ST_ADDR)
            begin
              if (sh_ff[7:1] == `TARGET_ADDR) // R8
              begin
                nxt_rw = sh_ff[0];
                nxt_first = 1'b1;
                nxt_drv = 1'b1; // R10
                nxt_st = afe_pkg::ST_AACK;
              end
              else
                nxt_st = afe_pkg::ST_IDLE;
            end
            else
            begin
              if (first_ff)
                nxt_ptr = sh_ff;
              else
              begin
                nxt_wr = 1'b1;
                nxt_wd = sh_ff;
              end
              nxt_drv = 1'b1;
              nxt_st = afe_pkg::ST_WACK;
            end
          end
        afe_pkg::ST_AACK, afe_pkg::ST_WACK:
          if (fall)
          begin
            if (st_ff == afe_pkg::ST_WACK && !first_ff)
              nxt_ptr = ptr_ff + 8'h01;
            if (st_ff == afe_pkg::ST_WACK)
              nxt_first = 1'b0;
            if (st_ff == afe_pkg::ST_AACK && rw_ff)
            begin
              nxt_sh = rif.rdata;
              nxt_drv = !rif.rdata[7];
              nxt_cnt = 4'h1;
              nxt_st = afe_pkg::ST_RDATA;
            end
            else
            begin
              nxt_drv = 1'b0;
              nxt_st = afe_pkg::ST_WDATA;
            end
          end
        afe_pkg::ST_RDATA:
          if (fall)
          begin
            if (cnt_ff == 4'h8)
            begin
              nxt_drv = 1'b0;
              nxt_ptr = ptr_ff + 8'h01;
              nxt_st = afe_pkg::ST_RACK;
            end
            else
            begin
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_drv = !sh_ff[6];
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        afe_pkg::ST_RACK:
          if (rise)
            nxt_st = sda_in ? afe_pkg::ST_IDLE : afe_pkg::ST_AACK;
      endcase
    end
  end

  // Mode decode into analog controls
  always_comb
  begin
    nxt_ctl = 4'h0;
    nxt_rt = 3'h0;
    unique case (afe_pkg::opm_t'(mode_reg[`OPM_MSB:`OPM_LSB])) // R1
      afe_pkg::OPM_GALVANIC: nxt_ctl = 4'b0110; // R5
      afe_pkg::OPM_STANDBY: nxt_ctl = 4'b1000;
      afe_pkg::OPM_AMPEROMETRIC: nxt_ctl = 4'b1100; // R4
      afe_pkg::OPM_TEMP_AMP_OFF: nxt_ctl = 4'b1001;
      afe_pkg::OPM_TEMP_AMP_ON:
      begin
        nxt_ctl = 4'b1101;
        nxt_rt = 3'b110; // R3
      end
      default: nxt_ctl = 4'h0;
    endcase
    nxt_rt[0] = mode_reg[`SHORT_BIT]; // R2
  end

  // Registers of engine and decode
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_ff <= afe_pkg::ST_IDLE;
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      sh_ff <= 8'h00;
      cnt_ff <= 4'h0;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      ptr_ff <= 8'h00;
      drv_ff <= 1'b0;
      wr_ff <= 1'b0;
      wd_ff <= 8'h00;
      ctl_ff <= 4'h0;
      rt_ff <= 3'h0;
    end
    else
    begin
      st_ff <= nxt_st;
      scl_ff <= nxt_scl;
      sda_ff <= nxt_sda;
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      rw_ff <= nxt_rw;
      first_ff <= nxt_first;
      ptr_ff <= nxt_ptr;
      drv_ff <= nxt_drv;
      wr_ff <= nxt_wr;
      wd_ff <= nxt_wd;
      ctl_ff <= nxt_ctl;
      rt_ff <= nxt_rt;
    end
  end

  // Outputs
  assign sda_out = 1'b0;
  assign sda_oe = drv_ff && sel; // R10
  assign control_amp_on = ctl_ff[3];
  assign current_to_voltage_amp_on = ctl_ff[2];
  assign current_to_voltage_non_inverting = ctl_ff[1];
  assign temp_sensor_on = ctl_ff[0];
  assign temp_to_main_output = rt_ff[2];
  assign pstat_to_second_feedback = rt_ff[1];
  assign electrode_short_switch_enable = rt_ff[0];
  assign gain_external = (gain_reg[`GAIN_MSB:`GAIN_LSB] == `GAIN_EXT);
endmodule : afe_mode_control_and_select

// ===== tb/afe_mode_checker.sv
// Port checker for the mode control block
`timescale 1ns/100ps
module afe_mode_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Bus and select
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic module_select_n,
  // Decoded controls
  input wire logic control_amp_on,
  input wire logic current_to_voltage_amp_on,
  input wire logic current_to_voltage_non_inverting,
  input wire logic temp_sensor_on,
  input wire logic temp_to_main_output,
  input wire logic pstat_to_second_feedback,
  input wire logic electrode_short_switch_enable,
  input wire logic device_ready
);
  logic [5:0] por_cnt_ff;
  logic [5:0] nxt_por_cnt;
  // Cycles since reset release, saturating
  always_comb nxt_por_cnt = (por_cnt_ff == 6'h3f) ? por_cnt_ff : por_cnt_ff + 6'h01;
  always_ff @(posedge ref_clk) por_cnt_ff <= sys_rst ? 6'h00 : nxt_por_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_desel_release: assert property (module_select_n |-> !sda_oe)
    else $error("data driven while deselected");
  // Data line must still be released when select returns
  a_sel_idle: assert property ($fell(module_select_n) |-> !sda_oe)
    else $error("data driven right after select");
  a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data driven in clock high");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
    !sda_oe && !device_ready && !control_amp_on && !electrode_short_switch_enable)
    else $error("outputs active after reset");
  a_ready_early: assert property (device_ready |-> por_cnt_ff >= 6'h27)
    else $error("ready too early");
  a_ready_late: assert property (por_cnt_ff == 6'h2c |-> device_ready)
    else $error("ready too late");
  a_route_temp: assert property ((temp_to_main_output || pstat_to_second_feedback) |->
    temp_to_main_output && pstat_to_second_feedback && temp_sensor_on && current_to_voltage_amp_on)
    else $error("output routing wrong");
  a_galv_ctrl: assert property (current_to_voltage_non_inverting |->
    current_to_voltage_amp_on && !control_amp_on)
    else $error("galvanic amplifier setup wrong");
  a_temp_ctrl: assert property (temp_sensor_on |-> control_amp_on)
    else $error("temperature mode without control amp");
  c_ack: cover property ($rose(sda_oe));
  c_route: cover property (temp_to_main_output);
  c_galv: cover property (current_to_voltage_non_inverting);
endmodule : afe_mode_checker
bind afe_mode_control_and_select afe_mode_checker i_afe_mode_checker (.*);

// ===== tb/host_bfm.sv
// Host controller model on the shared serial bus
`timescale 1ns/100ps
module host_bfm (
  // Clock
  input wire logic ref_clk,
  // Resolved data wire
  input wire logic sda_wire,
  // Host drives
  output logic scl,
  output logic sda_h,
  output logic sel_n
);
  logic [7:0] rx;
  // Bus idle, nothing selected
  initial
  begin
    scl = 1'b1;
    sda_h = 1'b1;
    sel_n = 1'b1;
  end
  // One bit, data set in clock low
  task automatic bitx(input logic b, output logic r);
    sda_h <= b;
    repeat (4) @(posedge ref_clk);
    scl <= 1'b1;
    repeat (2) @(posedge ref_clk);
    r = sda_wire;
    repeat (2) @(posedge ref_clk);
    scl <= 1'b0;
    @(posedge ref_clk);
  endtask : bitx
  // Byte plus acknowledge bit
  task automatic xbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(d[i], r);
      rx[i] = r;
    end
    bitx(1'b1, r);
    ack = !r;
  endtask : xbyte
  task automatic start;
    sda_h <= 1'b1;
    scl <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sda_h <= 1'b0;
    repeat (4) @(posedge ref_clk);
    scl <= 1'b0;
    @(posedge ref_clk);
  endtask : start
  task automatic stop;
    sda_h <= 1'b0;
    repeat (4) @(posedge ref_clk);
    scl <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sda_h <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask : stop
  // Select one device, then run a framed transfer
  task automatic sel(input logic en);
    sel_n <= !en;
    @(posedge ref_clk);
  endtask : sel
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, input logic en, output logic ok);
    logic k0, k1, k2;
    sel(en);
    start();
    xbyte({a, 1'b0}, k0);
    xbyte(p, k1);
    xbyte(d, k2);
    stop();
    sel(1'b0);
    ok = k0 & k1 & k2;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
    logic k;
    sel(1'b1);
    start();
    xbyte({a, 1'b0}, k);
    xbyte(p, k);
    stop();
    start();
    xbyte({a, 1'b1}, k);
    xbyte(8'hff, k);
    d = rx;
    stop();
    sel(1'b0);
  endtask : rd
  // Select dropped while the device drives read data
  task automatic abort(input logic [6:0] a);
    logic k;
    sel(1'b1);
    start();
    xbyte({a, 1'b1}, k);
    bitx(1'b1, k);
    sel(1'b0);
    stop();
  endtask : abort
endmodule : host_bfm

// ===== tb/afe_mode_control_and_select_test.sv
// Self-checking bench for the mode control block
`timescale 1ns/100ps
`include "afe_consts.svh"
module afe_mode_control_and_select_test;
  logic ref_clk, sys_rst, scl, sda_h, sel_n, sda_out, sda_oe, rdy, ack;
  logic [7:0] rv;
  wire [7:0] ctl;
  wire sda_wire;
  int err_total, compares;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  logic [5:0] exp_dec [6] = '{6'h00, 6'h18, 6'h20, 6'h30, 6'h24, 6'h37};
  // Open-drain wire with pull-up
  assign sda_wire = sda_h & (sda_out | ~sda_oe);
  afe_mode_control_and_select i_afe_mode_control_and_select (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .module_select_n(sel_n),
    .control_amp_on(ctl[5]), .current_to_voltage_amp_on(ctl[4]),
    .current_to_voltage_non_inverting(ctl[3]), .temp_sensor_on(ctl[2]),
    .temp_to_main_output(ctl[1]), .pstat_to_second_feedback(ctl[0]), .electrode_short_switch_enable(ctl[6]),
    .device_ready(rdy), .gain_external(ctl[7]));
  host_bfm i_host_bfm (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_h(sda_h), .sel_n(sel_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      err_total++;
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    final_report();
  end
  // Test sequence
  initial
  begin
    sys_rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk({rdy, ctl[6:0]}, 8'h00);
    repeat (45) @(posedge ref_clk);
    i_host_bfm.rd(`TARGET_ADDR, `OFS_STATUS, rv);
    chk(rv, 8'h01);
    i_host_bfm.rd(`TARGET_ADDR, `OFS_MODE, rv);
    chk(rv, `MODE_RST);
    $display("test reset done");
    i_host_bfm.wr(`TARGET_ADDR, `OFS_GAIN, 8'h03, 1'b1, ack);
    i_host_bfm.rd(`TARGET_ADDR, `OFS_GAIN, rv);
    chk({ack, rv[6:0]}, 8'h9c);
    i_host_bfm.wr(`TARGET_ADDR, `OFS_LOCK, 8'h00, 1'b1, ack);
    i_host_bfm.wr(`TARGET_ADDR, `OFS_GAIN, 8'h03, 1'b1, ack);
    i_host_bfm.wr(`TARGET_ADDR, `OFS_REF, 8'h60, 1'b1, ack);
    i_host_bfm.rd(`TARGET_ADDR, `OFS_REF, rv);
    chk(rv, 8'h60);
    chk(ctl, 8'h80);
    $display("test lock done");
    // Every mode code, short switch toggled alongside
    for (int i = 0; i < 6; i++)
    begin
      i_host_bfm.wr(`TARGET_ADDR, `OFS_MODE, {i[0], 4'h0, codes[i]}, 1'b1, ack);
      chk(ctl, {1'b1, i[0], exp_dec[i]});
      i_host_bfm.rd(`TARGET_ADDR, `OFS_MODE, rv);
      chk(rv, {i[0], 4'h0, codes[i]});
    end
    $display("test modes done");
    i_host_bfm.wr(`TARGET_ADDR, `OFS_MODE, 8'h00, 1'b0, ack);
    chk({ack, ctl[6:0]}, 8'h77);
    i_host_bfm.wr(7'h49, `OFS_MODE, 8'h00, 1'b1, ack);
    chk({ack, ctl[6:0]}, 8'h77);
    // Companion memory on the shared select, low address bit zero
    i_host_bfm.wr(7'h50, `OFS_MODE, 8'h00, 1'b1, ack);
    chk({ack, ctl[6:0]}, 8'h77);
    i_host_bfm.abort(`TARGET_ADDR);
    i_host_bfm.wr(`TARGET_ADDR, `OFS_MODE, 8'h00, 1'b1, ack);
    chk({ack, ctl[6:0]}, 8'h80);
    $display("test select done");
    final_report();
  end
endmodule : afe_mode_control_and_select_test
